// file: common/wdtu_pkg.sv
// package of constants and types for the watchdog timer unit
package wdtu_pkg;
   // register map, byte addresses on apb
   localparam logic [11:0] ADDR_CONTROL     = 12'h060;
   localparam logic [11:0] ADDR_RESET_CAUSE = 12'h064;
   localparam logic [11:0] ADDR_STRAPS      = 12'h068;
   // control register field positions
   localparam int BIT_FLAG     = 7;
   localparam int BIT_IRQ_EN   = 6;
   localparam int BIT_PS3      = 5;
   localparam int BIT_UNLOCK   = 4;
   localparam int BIT_RST_EN   = 3;
   localparam int BIT_PS_HI    = 2;
   // reset-cause register field position
   localparam int BIT_WD_CAUSE = 3;
   // reset values
   localparam logic [7:0] CONTROL_RESET  = 8'h00;
   localparam logic       RST_EN_RESET   = 1'b0;
   // timed sequence length, bus clock cycles
   localparam logic [2:0] UNLOCK_CYCLES  = 3'h4;
   // time-out table
   localparam logic [3:0] PS_MAX_CODE    = 4'h9;
   localparam int         TIMEOUT_BASE_LOG2 = 11;
   localparam int         OSC_KHZ        = 128;
   // reset pulse width, bus clock cycles
   localparam logic [1:0] RST_PULSE_CYCLES = 2'h1;
   typedef enum logic [1:0] {WDTU_STOPPED, WDTU_IRQ, WDTU_RESET, WDTU_IRQ_RESET} wdtu_mode_e;
endpackage : wdtu_pkg

// file: common/wdtu_tick_if.sv
// interface carrying oscillator ticks and counter restart between modules
`timescale 1ns/1ps
interface wdtu_tick_if;
   logic       tick;
   logic       restart;
   logic [3:0] prescale;
   logic       running;
   logic       timeout;
   modport ctrl (output restart, output prescale, output running, input tick, input timeout);
   modport cnt  (input restart, input prescale, input running, input tick, output timeout);
   modport osc  (output tick);
endinterface : wdtu_tick_if

// file: verilog/wdtu_osc_sync.sv
// synchroniser and edge detector for the watchdog oscillator clock
`timescale 1ns/1ps
module wdtu_osc_sync (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // oscillator in
   input  wire logic osc_clk,
   // tick out
   wdtu_tick_if.osc  tk
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic tick;
   } wdtu_sync_s;
   wdtu_sync_s st;
   wdtu_sync_s next_st;

   always_comb begin
      next_st      = st;
      next_st.s1   = osc_clk;
      next_st.s2   = st.s1;
      next_st.s3   = st.s2;
      // edge taken after s2 only; s1 feeds s2 alone
      next_st.tick = st.s2 & ~st.s3;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tk.tick = st.tick;
endmodule : wdtu_osc_sync

// file: verilog/wdtu_counter.sv
// watchdog counter counting oscillator ticks against the selected time-out
`timescale 1ns/1ps
module wdtu_counter #(
   parameter int CNT_W = 20
) (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // control side
   wdtu_tick_if.cnt  tk
);
   typedef struct packed {
      logic [CNT_W-1:0] count;
      logic             timeout;
   } wdtu_cnt_s;
   wdtu_cnt_s st;
   wdtu_cnt_s next_st;

   // last count of the period for a prescale code; reserved codes use the longest
   function automatic logic [CNT_W-1:0] last_count(input logic [3:0] code);
      logic [3:0] c;
      c = (code > wdtu_pkg::PS_MAX_CODE) ? wdtu_pkg::PS_MAX_CODE : code;
      return CNT_W'((64'h1 << (wdtu_pkg::TIMEOUT_BASE_LOG2 + int'(c))) - 64'h1);
   endfunction : last_count

   always_comb begin
      next_st         = st;
      next_st.timeout = 1'b0;
      if (tk.restart || !tk.running) begin
         next_st.count = '0;
      end else if (tk.tick) begin
         // compare with >= so a shorter period set mid-count fires on the next tick
         if (st.count >= last_count(tk.prescale)) begin
            next_st.count   = '0;
            next_st.timeout = 1'b1;
         end else begin
            next_st.count = st.count + CNT_W'(1);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tk.timeout = st.timeout;
endmodule : wdtu_counter

// file: verilog/wdtu_top.sv
// watchdog timer unit top: apb registers, mode logic, timed unlock
// Contract
// - counter advances on separate oscillator cycles
// - restart clears counter; time-out acts otherwise
// - mode from fuse, reset enable, irq enable
// - vector execution clears flag, and irq enable in irq-reset mode only
// - unserviced second time-out gives system reset
// - fuse forces reset enable one, irq zero
// - change bit self-clears after four cycles
// - clear reset or prescale only when unlocked
// - flag set on irq time-out, cleared by vector/one
// - irq requested only with global and local enable
// - clock monitor with irq enable forces reset mode, no interrupt
// - reset-cause flag holds reset enable set
// - control register layout and reset values
// - time-out interrupt can wake from sleep
// - prescale selects 2048 to 1048576 cycles
// - system reset is one clock pulse
// - cause flag set by watchdog reset, cleared by zero
`timescale 1ns/1ps
module wdtu_top (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // watchdog oscillator, asynchronous to pclk
   input  wire logic        osc_clk,
   // cpu side
   input  wire logic        restart_instr,
   input  wire logic        irq_vector_taken,
   input  wire logic        global_irq_enable,
   input  wire logic        always_on_fuse,
   input  wire logic        clock_monitor_sel,
   input  wire logic        power_on_reset,
   // outputs to the system
   output logic             timeout_irq,
   output logic             system_reset,
   output logic             wake_request
);
   typedef struct packed {
      logic        flag;
      logic        irq_en;
      logic [3:0]  prescale;
      logic        unlock;
      logic [2:0]  unlock_cnt;
      logic        rst_en;
      logic        cause;
      logic        fuse;
      logic        clkmon;
      logic        gie;
      logic [1:0]  rst_cnt;
      logic        sys_rst;
      logic        irq;
      logic        wake;
      logic [31:0] rdata;
      logic        ready;
      logic        slverr;
   } wdtu_top_s;

   typedef enum logic [1:0] {WDTU_SEL_NONE, WDTU_SEL_CONTROL, WDTU_SEL_CAUSE, WDTU_SEL_STRAPS}
      wdtu_sel_e;

   wdtu_top_s st;
   wdtu_top_s next_st;
   wdtu_tick_if tk ();

   wdtu_osc_sync u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .osc_clk (osc_clk),
      .tk      (tk.osc)
   );

   wdtu_counter #(.CNT_W(20)) u_cnt (
      .pclk    (pclk),
      .presetn (presetn),
      .tk      (tk.cnt)
   );

   // effective reset enable and irq enable after overrides
   // clock monitor alone leaves the unit stopped; beside irq enable it forces reset
   function automatic logic eff_rst(input wdtu_top_s s);
      return s.rst_en | s.fuse | s.cause | (s.clkmon & s.irq_en);
   endfunction : eff_rst

   function automatic logic eff_irq(input wdtu_top_s s);
      return s.irq_en & ~s.fuse & ~s.clkmon;
   endfunction : eff_irq

   // reads show the enables after overrides, not the stored bits
   function automatic logic [7:0] control_view(input wdtu_top_s s);
      logic [7:0] v;
      v                      = 8'h00;
      v[wdtu_pkg::BIT_FLAG]   = s.flag;
      v[wdtu_pkg::BIT_IRQ_EN] = eff_irq(s);
      v[wdtu_pkg::BIT_PS3]    = s.prescale[3];
      v[wdtu_pkg::BIT_UNLOCK] = s.unlock;
      v[wdtu_pkg::BIT_RST_EN] = eff_rst(s);
      v[wdtu_pkg::BIT_PS_HI:0] = s.prescale[2:0];
      return v;
   endfunction : control_view

   // one decode shared by the write strobes and the read mux
   function automatic wdtu_sel_e decode_addr(input logic [11:0] a);
      wdtu_sel_e r;
      r = WDTU_SEL_NONE;
      if (a == wdtu_pkg::ADDR_CONTROL) begin
         r = WDTU_SEL_CONTROL;
      end else if (a == wdtu_pkg::ADDR_RESET_CAUSE) begin
         r = WDTU_SEL_CAUSE;
      end else if (a == wdtu_pkg::ADDR_STRAPS) begin
         r = WDTU_SEL_STRAPS;
      end
      return r;
   endfunction : decode_addr

   wdtu_pkg::wdtu_mode_e mode;
   logic                 setup;
   logic                 wr_ctl;
   logic                 wr_cause;
   logic [7:0]           wd;
   wdtu_sel_e            sel;
   logic                 fire_reset;

   always_comb begin
      unique case ({eff_rst(st), eff_irq(st)})
         2'b00: mode = wdtu_pkg::WDTU_STOPPED;
         2'b01: mode = wdtu_pkg::WDTU_IRQ;
         2'b10: mode = wdtu_pkg::WDTU_RESET;
         2'b11: mode = wdtu_pkg::WDTU_IRQ_RESET;
      endcase
   end

   assign setup    = psel & ~penable;
   assign wd       = pwdata[7:0];
   assign sel      = decode_addr(paddr);
   // writes land in the access phase; pready is high then
   assign wr_ctl   = psel & penable & pwrite & pstrb[0] & (sel == WDTU_SEL_CONTROL);
   assign wr_cause = psel & penable & pwrite & pstrb[0] & (sel == WDTU_SEL_CAUSE);

   assign tk.restart  = restart_instr;
   assign tk.prescale = st.prescale;
   // stopped holds the count at zero, so enabling always starts a full period
   assign tk.running  = (mode != wdtu_pkg::WDTU_STOPPED);

   always_comb begin
      next_st          = st;
      // straps are same-clock inputs, taken one cycle late
      next_st.fuse     = always_on_fuse;
      next_st.clkmon   = clock_monitor_sel;
      next_st.gie      = global_irq_enable;
      next_st.sys_rst  = 1'b0;
      fire_reset       = 1'b0;
      next_st.ready    = setup;
      next_st.slverr   = 1'b0;
      next_st.rdata    = 32'h0000_0000;

      // unlock window countdown
      if (st.unlock) begin
         if (st.unlock_cnt == wdtu_pkg::UNLOCK_CYCLES - 3'h1) begin
            next_st.unlock     = 1'b0;
            next_st.unlock_cnt = 3'h0;
         end else begin
            next_st.unlock_cnt = st.unlock_cnt + 3'h1;
         end
      end

      // software write to control register
      if (wr_ctl) begin
         next_st.irq_en = wd[wdtu_pkg::BIT_IRQ_EN];
         if (wd[wdtu_pkg::BIT_FLAG]) begin
            next_st.flag = 1'b0;
         end
         // a second unlocking write restarts the window from zero
         if (wd[wdtu_pkg::BIT_UNLOCK] && wd[wdtu_pkg::BIT_RST_EN]) begin
            next_st.unlock     = 1'b1;
            next_st.unlock_cnt = 3'h0;
            next_st.rst_en     = 1'b1;
         end else if (st.unlock) begin
            // allowed change inside the window
            next_st.rst_en   = wd[wdtu_pkg::BIT_RST_EN];
            next_st.prescale = {wd[wdtu_pkg::BIT_PS3], wd[wdtu_pkg::BIT_PS_HI:0]};
            next_st.unlock   = 1'b0;
         end else if (wd[wdtu_pkg::BIT_RST_EN]) begin
            // setting is always allowed; clearing and prescale are kept
            next_st.rst_en = 1'b1;
         end
      end

      // cause flag held reset enable cannot be cleared
      if (st.cause) begin
         next_st.rst_en = 1'b1;
      end
      if (st.fuse) begin
         next_st.rst_en = 1'b1;
         next_st.irq_en = 1'b0;
      end

      // cause register write: zero clears the flag
      if (wr_cause && !wd[wdtu_pkg::BIT_WD_CAUSE]) begin
         next_st.cause = 1'b0;
      end
      if (power_on_reset) begin
         next_st.cause = 1'b0;
      end

      // vector execution clears flag; irq enable only in irq-reset mode
      if (irq_vector_taken) begin
         next_st.flag = 1'b0;
         if (mode == wdtu_pkg::WDTU_IRQ_RESET) begin
            next_st.irq_en = 1'b0;
         end
      end

      // time-out action; placed last so an event beats a same-cycle clear
      if (tk.timeout) begin
         unique case (mode)
            wdtu_pkg::WDTU_STOPPED: begin
            end
            wdtu_pkg::WDTU_IRQ: begin
               next_st.flag = 1'b1;
            end
            wdtu_pkg::WDTU_RESET: begin
               fire_reset = 1'b1;
            end
            wdtu_pkg::WDTU_IRQ_RESET: begin
               if (st.flag) begin
                  fire_reset = 1'b1;
               end else begin
                  next_st.flag = 1'b1;
               end
            end
         endcase
      end

      // stretch the reset to its set width; a new time-out reloads the count
      if (st.rst_cnt != 2'h0) begin
         next_st.rst_cnt = st.rst_cnt - 2'h1;
         next_st.sys_rst = 1'b1;
      end
      if (fire_reset) begin
         next_st.sys_rst = 1'b1;
         next_st.rst_cnt = wdtu_pkg::RST_PULSE_CYCLES - 2'h1;
      end
      if (next_st.sys_rst) begin
         next_st.cause = 1'b1;
      end

      // irq output and sleep wake
      next_st.irq  = next_st.flag & next_st.irq_en & ~st.fuse & ~st.clkmon
                     & global_irq_enable;
      next_st.wake = next_st.flag & next_st.irq_en & ~st.fuse & ~st.clkmon;

      // read data in setup; unmapped addresses read zero and flag an error
      if (setup) begin
         unique case (sel)
            WDTU_SEL_CONTROL: begin
               next_st.rdata = {24'h000000, control_view(st)};
            end
            WDTU_SEL_CAUSE: begin
               next_st.rdata = 32'(st.cause) << wdtu_pkg::BIT_WD_CAUSE;
            end
            WDTU_SEL_STRAPS: begin
               next_st.rdata = {29'h0, st.gie, st.clkmon, st.fuse};
            end
            WDTU_SEL_NONE: begin
               next_st.slverr = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st          <= '0;
         // reset enable starts clear so the unit comes up stopped
         st.rst_en   <= wdtu_pkg::RST_EN_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign prdata       = st.rdata;
   assign pready       = st.ready;
   assign pslverr      = st.slverr;
   assign timeout_irq  = st.irq;
   assign system_reset = st.sys_rst;
   assign wake_request = st.wake;
endmodule : wdtu_top

// file: testbench/wdtu_top_asserts.sv
// port checker for the watchdog timer unit
`timescale 1ns/1ps
module wdtu_top_asserts (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // system
   input wire logic        global_irq_enable,
   input wire logic        always_on_fuse,
   input wire logic        timeout_irq,
   input wire logic        system_reset,
   input wire logic        wake_request
);
   logic mapped;
   assign mapped = paddr == wdtu_pkg::ADDR_CONTROL || paddr == wdtu_pkg::ADDR_RESET_CAUSE
                   || paddr == wdtu_pkg::ADDR_STRAPS;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no pready after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_slverr_unmapped: assert property (pready |-> pslverr == !mapped)
      else $error("pslverr wrong for address");
   a_upper_bits_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
      else $error("upper read bits not zero");
   a_irq_global_gate: assert property (timeout_irq |-> $past(global_irq_enable))
      else $error("irq without global enable");
   a_irq_wakes: assert property (timeout_irq |-> wake_request)
      else $error("irq without wake request");
   a_fuse_no_irq: assert property (always_on_fuse && $past(always_on_fuse, 2) |-> !wake_request)
      else $error("interrupt path live under fuse");
   a_reset_one_pulse: assert property (system_reset |=> !system_reset)
      else $error("system reset longer than one cycle");
endmodule : wdtu_top_asserts

// file: testbench/wdtu_top_tb.sv
// self-checking testbench for the watchdog timer unit
`timescale 1ns/1ps
module wdtu_top_tb;
   logic        pclk, presetn, psel, penable, pwrite, osc_clk, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb;
   logic        restart_instr, irq_vector_taken, global_irq_enable, always_on_fuse;
   logic        clock_monitor_sel, power_on_reset, timeout_irq, system_reset, wake_request;
   int          n_mismatch, samples_checked, cycles, rst_count, cyc;
   localparam logic [11:0] CTL = wdtu_pkg::ADDR_CONTROL;
   localparam logic [11:0] CAU = wdtu_pkg::ADDR_RESET_CAUSE;
   // oscillator half period 18 ns, so one tick every 4.5 bus cycles
   localparam int PER = (1 << wdtu_pkg::TIMEOUT_BASE_LOG2) * 36 / 8;
   wdtu_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .osc_clk, .restart_instr, .irq_vector_taken,
      .global_irq_enable, .always_on_fuse, .clock_monitor_sel, .power_on_reset,
      .timeout_irq, .system_reset, .wake_request);
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   initial begin
      osc_clk = 1'b0;
      forever #18 osc_clk = ~osc_clk;
   end
   always @(negedge pclk) begin
      cycles++;
      if (system_reset === 1'b1) rst_count++;
      if (cycles > 80000) begin
         n_mismatch++;
         stop_test();
      end
   end
   task stop_test();
      $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : stop_test
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      // read before the edge's own updates, so this is what the edge samples
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
         n++;
      end
      chk("pready wait", 32'h0, n);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   task rdk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd & m);
   endtask : rdk
   task unlock_wr(input logic [31:0] d);
      apb(1'b1, CTL, 32'h18);
      apb(1'b1, CTL, d);
   endtask : unlock_wr
   task wait_out(input int s, input int lim, input bit quiet);
      cyc = 0;
      @(negedge pclk);
      while ((s == 0 ? timeout_irq : s == 1 ? wake_request : system_reset) !== 1'b1
             && cyc < lim) begin
         @(negedge pclk);
         cyc++;
      end
      if (!quiet) chk("output raised in time", 1'b1, cyc < lim);
   endtask : wait_out
   task pulse_vector();
      @(posedge pclk) irq_vector_taken <= 1'b1;
      @(posedge pclk) irq_vector_taken <= 1'b0;
      repeat (2) @(negedge pclk);
   endtask : pulse_vector
   task t_reset();
      rdk(CTL, 32'hff, 32'h00, "control reset");
      rdk(CAU, 32'hff, 32'h00, "cause reset");
      apb(1'b0, 12'h06c, 32'h0);
      chk("unmapped err", 1'b1, err);
      chk("unmapped data", 32'h0, rd);
      apb(1'b1, CAU, 32'h0);
      unlock_wr(32'h0);
      rdk(CTL, 32'hff, 32'h00, "init leaves unit stopped");
   endtask : t_reset
   task t_irq_mode();
      apb(1'b1, CTL, 32'h40);
      wait_out(1, 12000, 0);
      chk("period", 1'b1, cyc > PER - 40 && cyc < PER + 40);
      chk("masked irq", 1'b0, timeout_irq);
      rdk(CTL, 32'hff, 32'hc0, "flag set");
      @(posedge pclk) global_irq_enable <= 1'b1;
      repeat (3) @(negedge pclk);
      chk("irq on enable", 1'b1, timeout_irq);
      pulse_vector();
      rdk(CTL, 32'hff, 32'h40, "vector clears flag");
      chk("no reset in irq mode", 0, rst_count);
   endtask : t_irq_mode
   task t_restart();
      @(posedge pclk) restart_instr <= 1'b1;
      wait_out(1, 10000, 1);
      chk("restart holds off", 10000, cyc);
      @(posedge pclk) restart_instr <= 1'b0;
      wait_out(1, 12000, 0);
      chk("period after restart", 1'b1, cyc > PER - 40 && cyc < PER + 40);
      apb(1'b1, CTL, 32'hc8);
      rdk(CTL, 32'hff, 32'h48, "flag write one");
   endtask : t_restart
   task t_irq_reset();
      wait_out(0, 12000, 0);
      chk("first timeout no reset", 0, rst_count);
      pulse_vector();
      rdk(CTL, 32'hff, 32'h08, "vector to reset mode");
      apb(1'b1, CTL, 32'h48);
      wait_out(0, 12000, 0);
      chk("re-armed no reset", 0, rst_count);
      wait_out(2, 12000, 0);
      repeat (2) @(negedge pclk);
      chk("unserviced reset", 1, rst_count);
      rdk(CAU, 32'hff, 32'h08, "cause set");
      unlock_wr(32'h80);
      rdk(CTL, 32'h08, 32'h08, "cause holds reset enable");
      apb(1'b1, CAU, 32'h0);
      rdk(CAU, 32'hff, 32'h00, "cause cleared");
      unlock_wr(32'h80);
      rdk(CTL, 32'hff, 32'h00, "watchdog off");
   endtask : t_irq_reset
   task t_force();
      for (int i = 0; i < 2; i++) begin
         @(posedge pclk);
         if (i == 0) always_on_fuse <= 1'b1;
         else clock_monitor_sel <= 1'b1;
         repeat (3) @(posedge pclk);
         rdk(CTL, 32'hff, (i == 0) ? 32'h08 : 32'h00, "override alone");
         apb(1'b1, CTL, 32'h40);
         rdk(CTL, 32'hff, 32'h08, "forced reset mode");
         if (i == 0) begin
            wait_out(2, 12000, 0);
            rdk(CAU, 32'hff, 32'h08, "fuse reset cause");
            @(posedge pclk) power_on_reset <= 1'b1;
            @(posedge pclk) power_on_reset <= 1'b0;
            rdk(CAU, 32'hff, 32'h00, "power-on clears cause");
         end
         @(posedge pclk);
         always_on_fuse <= 1'b0; clock_monitor_sel <= 1'b0;
         repeat (3) @(posedge pclk);
         unlock_wr(32'h0);
         rdk(CTL, 32'hff, 32'h00, "released");
      end
   endtask : t_force
   task t_unlock();
      apb(1'b1, CTL, 32'h18);
      rdk(CTL, 32'hff, 32'h18, "unlock open");
      repeat (4) @(posedge pclk);
      rdk(CTL, 32'hff, 32'h08, "unlock self clears");
      apb(1'b1, CTL, 32'h47);
      rdk(CTL, 32'hff, 32'h48, "locked bits kept");
      @(posedge pclk) restart_instr <= 1'b1;
      @(posedge pclk) restart_instr <= 1'b0;
      unlock_wr(32'h21);
      rdk(CTL, 32'hff, 32'h21, "unlocked setting");
   endtask : t_unlock
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0;
      pwdata = 32'h0; pstrb = 4'hf; restart_instr = 1'b0; irq_vector_taken = 1'b0;
      global_irq_enable = 1'b0; always_on_fuse = 1'b0; clock_monitor_sel = 1'b0;
      power_on_reset = 1'b0; n_mismatch = 0; samples_checked = 0; cycles = 0; rst_count = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_irq_mode();
      t_restart();
      t_irq_reset();
      t_force();
      t_unlock();
      stop_test();
   end
endmodule : wdtu_top_tb
bind wdtu_top wdtu_top_asserts u_chk (.pclk, .presetn, .psel, .penable, .paddr, .prdata,
   .pready, .pslverr, .global_irq_enable, .always_on_fuse, .timeout_irq, .system_reset,
   .wake_request);
